//--- rtl/host_port_pkg.sv
// Behaviour
// - one shared eight-bit two-way data bus
// - host presents sixteen-bit access address
// - accesses happen only with chip select low
// - interrupt request is open-drain, active low
// - interrupt released when idle, low when pending
// - interrupt stays low until all serviced
// - address captured on latch strobe falling edge in strobe mode, rising edge in processor mode
// - address captured only while chip select low
// - read strobe low drives addressed register out, in processor mode only while the write pin is high
// - read strobe high releases the data bus
// - write data stored at write strobe rising in strobe mode, at read strobe rising in processor mode
// - port offers strobe mode and processor mode
// - supports polling and interrupt driven software
package host_port_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 16;
    // strobe style selects: separate strobes or processor bus
    typedef enum logic {
        MODE_STROBE,
        MODE_PROC
    } bus_mode_t;
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
    // host keeps each strobe phase at least this many cycles so two-stage sync sees it
    localparam int PHASE_CYCLES = 4;
endpackage

//--- rtl/host_port_if.sv
`timescale 1ns/100ps
`default_nettype none
interface host_port_if;
    import host_port_pkg::*;
    logic [DATA_W-1:0] data_from_host;
    logic              data_host_oe;
    logic [DATA_W-1:0] data_from_dev;
    logic              data_dev_oe;
    logic [ADDR_W-1:0] addr;
    logic              chip_sel_n;
    logic              addr_latch_strobe;
    logic              read_strobe_n;
    logic              write_strobe_n;
    logic              irq_out;
    logic              irq_oe;
    // resolved wire levels
    logic [DATA_W-1:0] data_bus;
    logic              irq_n;
    assign data_bus = data_dev_oe ? data_from_dev :
                      (data_host_oe ? data_from_host : {DATA_W{1'b1}});
    assign irq_n = irq_oe ? irq_out : 1'b1;
    modport device (
        input  data_bus, addr, chip_sel_n, addr_latch_strobe, read_strobe_n,
               write_strobe_n,
        output data_from_dev, data_dev_oe, irq_out, irq_oe
    );
    modport host (
        input  data_bus, irq_n,
        output data_from_host, data_host_oe, addr, chip_sel_n, addr_latch_strobe,
               read_strobe_n, write_strobe_n
    );
endinterface
`default_nettype wire

//--- rtl/host_port_device.sv
`timescale 1ns/100ps
`default_nettype none
module host_port_device
    import host_port_pkg::*;
#(
    parameter int REG_COUNT = 16,
    parameter int IRQ_W     = 4
) (
    input  wire logic              clk_sys,
    input  wire logic              rst_b,
    host_port_if.device            bus,
    input  wire logic              bus_mode,
    input  wire logic [IRQ_W-1:0]  irq_event,
    output logic [DATA_W-1:0]      reg_view,
    output logic [IRQ_W-1:0]       irq_pending
);
    localparam int IDX_W = $clog2(REG_COUNT);

    // ------------------------------------------------------------
    // overview
    // ------------------------------------------------------------
    // the host strobes arrive with no relation to clk_sys, so every pin
    // is passed through two flops before any decision is made on it.
    // one further flop per strobe keeps the previous synced level, and
    // the edge detectors compare that with the current synced level.
    // the price is latency: a strobe edge is acted on three clock edges
    // after it reaches the pins, so a host must hold each phase longer
    // than that or the edge is lost.
    // address and data are synced with the same depth as the strobes,
    // so when an edge is seen the matching address or data word has
    // already settled in the second stage; the host keeps both steady
    // across the whole phase, which makes the multi-bit crossing safe.
    // register 0 is the pending-interrupt status word: reading it shows
    // every pending source, writing ones clears those sources. a source
    // that fires in the same cycle as its clear stays pending, so no
    // event is ever lost to a badly timed service write.
    // registers 1 up to REG_COUNT-1 are plain storage.
    // addresses at or above REG_COUNT read as zero and ignore writes;
    // the full sixteen-bit latch is compared, so nothing aliases.
    // the interrupt pin is open drain: only a low level is ever driven,
    // and the line is released as soon as no source is pending.
    // in processor mode the pins change roles: the latch strobe is an
    // active-low address strobe latched on its rising edge, the read
    // pin is the data strobe and the write pin carries read/not-write.
    // a host speaking strobe style while the port is in processor mode
    // can still read, but its writes never raise the data strobe and
    // are therefore dropped.
    // limitation: there is no ready or acknowledge output, so the host
    // must know the fixed latency and pace its phases accordingly.

    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    logic [3:0] sync1, sync2, next_sync1, next_sync2;
    logic [DATA_W-1:0] dat1, dat2;
    logic [ADDR_W-1:0] adr1, adr2;
    logic ale_q, rd_q, wr_q, next_ale_q, next_rd_q, next_wr_q;
    always_comb begin
        next_sync1 = {bus.chip_sel_n, bus.addr_latch_strobe, bus.read_strobe_n,
                      bus.write_strobe_n};
        next_sync2 = sync1;
        next_ale_q = sync2[2];
        next_rd_q  = sync2[1];
        next_wr_q  = sync2[0];
    end
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            // idle pin levels: select high, latch low, strobes high
            sync1 <= 4'hB;
            sync2 <= 4'hB;
            ale_q <= 1'b0;
            rd_q  <= 1'b1;
            wr_q  <= 1'b1;
            dat1  <= DATA_RESET;
            dat2  <= DATA_RESET;
            adr1  <= ADDR_RESET;
            adr2  <= ADDR_RESET;
        end else begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            ale_q <= next_ale_q;
            rd_q  <= next_rd_q;
            wr_q  <= next_wr_q;
            dat1  <= bus.data_bus;
            dat2  <= dat1;
            adr1  <= bus.addr;
            adr2  <= adr1;
        end
    end
    wire cs_ok = !sync2[3];
    // mode selects strobe decode
    // processor mode: latch strobe low-active, read line is data strobe,
    // write line is read/not-write; strobe mode uses separate strobes
    wire ale_fall = (bus_mode == MODE_PROC) ? (sync2[2] && !ale_q) : (!sync2[2] && ale_q);
    wire rd_act   = (bus_mode == MODE_PROC) ? (!sync2[1] && sync2[0]) : !sync2[1];
    wire wr_rise  = (bus_mode == MODE_PROC) ? (sync2[1] && !rd_q && !wr_q)
                                            : (sync2[0] && !wr_q);

    // ------------------------------------------------------------
    // address latch and register file
    // ------------------------------------------------------------
    logic [ADDR_W-1:0] addr_lat, next_addr_lat;
    logic [DATA_W-1:0] regs [REG_COUNT];
    logic [DATA_W-1:0] next_regs [REG_COUNT];
    logic [IRQ_W-1:0]  pend, next_pend;
    logic [DATA_W-1:0] rdata, next_rdata;
    logic              doe, next_doe, irq_drv, next_irq_drv;
    wire  [IDX_W-1:0]  idx = addr_lat[IDX_W-1:0];
    wire               hit = (addr_lat < ADDR_W'(REG_COUNT));
    always_comb begin
        next_addr_lat = addr_lat;
        if (ale_fall && cs_ok) begin
            next_addr_lat = adr2;
        end
        for (int i = 0; i < REG_COUNT; i++) begin
            next_regs[i] = regs[i];
        end
        if (wr_rise && cs_ok && hit && idx != '0) begin
            next_regs[idx] = dat2;
        end
        // register 0 is pending status, write one to clear; set wins
        next_pend = pend;
        if (wr_rise && cs_ok && addr_lat == ADDR_RESET) begin
            next_pend = pend & ~dat2[IRQ_W-1:0];
        end
        next_pend = next_pend | irq_event;
        next_doe   = rd_act && cs_ok;
        next_rdata = !hit ? DATA_RESET :
                     (idx == '0) ? DATA_W'(pend) : regs[idx];
        next_irq_drv = |pend;
    end
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            addr_lat <= ADDR_RESET;
            for (int i = 0; i < REG_COUNT; i++) begin
                regs[i] <= DATA_RESET;
            end
            pend    <= '0;
            rdata   <= DATA_RESET;
            doe     <= 1'b0;
            irq_drv <= 1'b0;
        end else begin
            addr_lat <= next_addr_lat;
            regs     <= next_regs;
            pend     <= next_pend;
            rdata    <= next_rdata;
            doe      <= next_doe;
            irq_drv  <= next_irq_drv;
        end
    end

    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    // shared data bus
    assign bus.data_from_dev = rdata;
    assign bus.data_dev_oe   = doe;
    assign bus.irq_out = 1'b0;
    assign bus.irq_oe  = irq_drv;
    assign reg_view    = regs[1];
    assign irq_pending = pend;
endmodule
`default_nettype wire

//--- rtl/host_port_host.sv
`timescale 1ns/100ps
`default_nettype none
module host_port_host
    import host_port_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              rst_b,
    host_port_if.host              bus,
    input  wire logic              req,
    input  wire logic              req_write,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [DATA_W-1:0] req_wdata,
    output logic                   busy,
    output logic                   done,
    output logic [DATA_W-1:0]      rdata,
    output logic                   irq_seen
);
    typedef enum {
        ST_IDLE, ST_ALE, ST_ALE_FALL, ST_STROBE, ST_END
    } hstate_t;
    hstate_t state, next_state;
    logic [2:0] cnt, next_cnt;
    logic [ADDR_W-1:0] addr, next_addr;
    logic [DATA_W-1:0] wd, next_wd, rd, next_rd;
    logic wr, next_wr, cs_n, next_cs_n, ale, next_ale, rds_n, next_rds_n;
    logic wrs_n, next_wrs_n, oe, next_oe, dn, next_dn, bz, next_bz;
    logic irq1, irq2;

    // ------------------------------------------------------------
    // access sequencer, strobe mode
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_cnt = cnt + 3'(1);
        next_addr = addr;
        next_wd = wd;
        next_rd = rd;
        next_wr = wr;
        next_cs_n = cs_n;
        next_ale = ale;
        next_rds_n = rds_n;
        next_wrs_n = wrs_n;
        next_oe = oe;
        next_dn = 1'b0;
        next_bz = 1'b1;
        case (state)
            ST_IDLE: begin
                next_bz = 1'b0;
                next_cnt = '0;
                if (req) begin
                    next_addr = req_addr;
                    next_wd = req_wdata;
                    next_wr = req_write;
                    next_cs_n = 1'b0;
                    next_ale = 1'b1;
                    next_bz = 1'b1;
                    next_state = ST_ALE;
                end
            end
            ST_ALE: if (cnt == 3'(PHASE_CYCLES - 1)) begin
                next_ale = 1'b0;
                next_cnt = '0;
                next_state = ST_ALE_FALL;
            end
            ST_ALE_FALL: if (cnt == 3'(PHASE_CYCLES - 1)) begin
                next_cnt = '0;
                next_rds_n = wr;
                next_wrs_n = !wr;
                next_oe = wr;
                next_state = ST_STROBE;
            end
            ST_STROBE: if (cnt == 3'(PHASE_CYCLES + 2)) begin
                next_cnt = '0;
                next_rd = bus.data_bus;
                next_rds_n = 1'b1;
                next_wrs_n = 1'b1;
                next_state = ST_END;
            end
            ST_END: if (cnt == 3'(PHASE_CYCLES - 1)) begin
                next_oe = 1'b0;
                next_cs_n = 1'b1;
                next_dn = 1'b1;
                next_state = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
    end
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state <= ST_IDLE;
            cnt <= '0;
            addr <= ADDR_RESET;
            wd <= DATA_RESET;
            rd <= DATA_RESET;
            wr <= 1'b0;
            cs_n <= 1'b1;
            ale <= 1'b0;
            rds_n <= 1'b1;
            wrs_n <= 1'b1;
            oe <= 1'b0;
            dn <= 1'b0;
            bz <= 1'b0;
            irq1 <= 1'b0;
            irq2 <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            addr <= next_addr;
            wd <= next_wd;
            rd <= next_rd;
            wr <= next_wr;
            cs_n <= next_cs_n;
            ale <= next_ale;
            rds_n <= next_rds_n;
            wrs_n <= next_wrs_n;
            oe <= next_oe;
            dn <= next_dn;
            bz <= next_bz;
            irq1 <= !bus.irq_n;
            irq2 <= irq1;
        end
    end
    assign bus.data_from_host = wd;
    assign bus.data_host_oe = oe;
    assign bus.addr = addr;
    assign bus.chip_sel_n = cs_n;
    assign bus.addr_latch_strobe = ale;
    assign bus.read_strobe_n = rds_n;
    assign bus.write_strobe_n = wrs_n;
    assign busy = bz;
    assign done = dn;
    assign rdata = rd;
    assign irq_seen = irq2;
endmodule
`default_nettype wire

//--- testbench/host_port_checker.sv
`timescale 1ns/100ps
`default_nettype none
module host_port_checker
    import host_port_pkg::*;
(
    input wire logic              clk_sys,
    input wire logic              rst_b,
    input wire logic [DATA_W-1:0] data_bus,
    input wire logic              data_host_oe,
    input wire logic              data_dev_oe,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic              chip_sel_n,
    input wire logic              addr_latch_strobe,
    input wire logic              read_strobe_n,
    input wire logic              write_strobe_n,
    input wire logic              irq_out,
    input wire logic              irq_oe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // ----------------------------------------
    // wire-level checks, both ends
    // ----------------------------------------
    AST_NO_FIGHT: assert property (!(data_dev_oe && data_host_oe))
        else $error("both ends drive the data bus");
    AST_LATCH_SAFE: assert property ($fell(addr_latch_strobe) |-> !chip_sel_n && $stable(addr))
        else $error("address latched without select or while moving");
    AST_STROBE_SEL: assert property (!read_strobe_n || !write_strobe_n |-> !chip_sel_n)
        else $error("strobe seen with select high");
    // sync chain is two deep plus the drive flop, so drive follows the strobe by three cycles
    AST_READ_ON: assert property ($fell(read_strobe_n) |-> ##3 data_dev_oe)
        else $error("read data not driven in time");
    AST_READ_OFF: assert property ($rose(read_strobe_n) |-> ##3 !data_dev_oe)
        else $error("data bus not released after read");
    AST_DRIVE_CAUSE: assert property (data_dev_oe |->
        !$past(read_strobe_n, 3) && !$past(chip_sel_n, 3))
        else $error("device drives without a selected read");
    AST_WRITE_HELD: assert property (!write_strobe_n && !$past(write_strobe_n) |->
        data_host_oe && $stable(data_bus))
        else $error("write data moved while strobe low");
    AST_IRQ_OD: assert property (irq_oe |-> !irq_out)
        else $error("interrupt line driven high");
    // a short strobe would slip through the two-stage sync
    AST_READ_WIDTH: assert property ($fell(read_strobe_n) |->
        !read_strobe_n [*7] ##1 read_strobe_n)
        else $error("read strobe width wrong");
endmodule
`default_nettype wire

//--- testbench/async_host_register_port_tb.sv
`timescale 1ns/100ps
`default_nettype none
module async_host_register_port_tb;
    import host_port_pkg::*;
    logic              clk_sys;
    logic              rst_b;
    logic              req;
    logic              req_write;
    logic [ADDR_W-1:0] req_addr;
    logic [DATA_W-1:0] req_wdata;
    logic              busy;
    logic              done;
    logic [DATA_W-1:0] rdata;
    logic              irq_seen;
    logic [3:0]        irq_event;
    logic              bus_mode;
    logic [DATA_W-1:0] reg_view;
    logic [3:0]        irq_pending;
    logic [DATA_W-1:0] got;
    int                fail_count;
    int                n_tests;

    host_port_if bus_if ();
    host_port_host host_port_host_i (.clk_sys(clk_sys), .rst_b(rst_b), .bus(bus_if.host),
        .req(req), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .busy(busy), .done(done), .rdata(rdata), .irq_seen(irq_seen));
    // processor-bus mode has no host here, so the strobe-style host drives the port in both modes
    host_port_device #(.REG_COUNT(16), .IRQ_W(4)) host_port_device_i (.clk_sys(clk_sys),
        .rst_b(rst_b), .bus(bus_if.device), .bus_mode(bus_mode), .irq_event(irq_event),
        .reg_view(reg_view), .irq_pending(irq_pending));
    host_port_checker host_port_checker_i (.clk_sys(clk_sys), .rst_b(rst_b),
        .data_bus(bus_if.data_bus), .data_host_oe(bus_if.data_host_oe),
        .data_dev_oe(bus_if.data_dev_oe), .addr(bus_if.addr), .chip_sel_n(bus_if.chip_sel_n),
        .addr_latch_strobe(bus_if.addr_latch_strobe), .read_strobe_n(bus_if.read_strobe_n),
        .write_strobe_n(bus_if.write_strobe_n), .irq_out(bus_if.irq_out),
        .irq_oe(bus_if.irq_oe));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // called at a falling edge; req is held for one rising edge only
    task automatic access(input logic wr, input logic [15:0] a, input logic [7:0] d);
        int n;
        req = 1'b1;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        @(negedge clk_sys);
        req = 1'b0;
        check("busy", {7'h00, busy}, 8'h01);
        n = 0;
        while (done !== 1'b1 && n < 100) begin
            @(negedge clk_sys);
            n++;
        end
        check("done", {7'h00, done}, 8'h01);
        got = rdata;
    endtask

    task automatic pulse_irq(input logic [3:0] ev);
        irq_event = ev;
        @(negedge clk_sys);
        irq_event = 4'h0;
        repeat (6) @(negedge clk_sys);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------
    // clock, watchdog, tests
    // ----------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // about 40 accesses of some 20 cycles each; 5000 cycles is ample
    initial begin
        #(40 * 5000);
        $display("watchdog expired");
        fail_count++;
        tally_and_finish();
    end

    initial begin
        rst_b = 1'b0;
        req = 1'b0;
        req_write = 1'b0;
        req_addr = 16'h0000;
        req_wdata = 8'h00;
        irq_event = 4'h0;
        bus_mode = 1'b0;
        fail_count = 0;
        n_tests = 0;
        repeat (3) @(negedge clk_sys);
        rst_b = 1'b1;
        @(negedge clk_sys);
        check("irq idle", {7'h00, bus_if.irq_n}, 8'h01);
        check("bus free", {7'h00, bus_if.data_dev_oe}, 8'h00);
        // back-to-back writes then reads over every plain register
        for (int i = 1; i < 16; i++) access(1'b1, 16'(i), 8'hA0 ^ 8'(i * 3));
        check("view", reg_view, 8'hA3);
        for (int i = 1; i < 16; i++) begin
            access(1'b0, 16'(i), 8'h00);
            check("reg", got, 8'hA0 ^ 8'(i * 3));
        end
        // full sixteen-bit decode: no aliasing above the register range
        access(1'b1, 16'h8001, 8'h5A);
        access(1'b1, 16'h0010, 8'h5A);
        check("alias", reg_view, 8'hA3);
        access(1'b0, 16'h0010, 8'h00);
        check("unmapped", got, 8'h00);
        access(1'b0, 16'hFFFF, 8'h00);
        check("top", got, 8'h00);
        // interrupt raise, poll, partial and full service
        pulse_irq(4'h4);
        check("irq low", {7'h00, bus_if.irq_n}, 8'h00);
        check("irq seen", {7'h00, irq_seen}, 8'h01);
        access(1'b0, 16'h0000, 8'h00);
        check("status", got, 8'h04);
        pulse_irq(4'h1);
        access(1'b1, 16'h0000, 8'h04);
        check("irq held", {7'h00, bus_if.irq_n}, 8'h00);
        access(1'b0, 16'h0000, 8'h00);
        check("status2", got, 8'h01);
        access(1'b1, 16'h0000, 8'h01);
        repeat (4) @(negedge clk_sys);
        check("pending", {4'h0, irq_pending}, 8'h00);
        check("irq freed", {7'h00, bus_if.irq_n}, 8'h01);
        // processor mode: strobe-style write never raises data strobe
        bus_mode = 1'b1;
        access(1'b1, 16'h0002, 8'h33);
        access(1'b0, 16'h0002, 8'h00);
        check("proc mode", got, 8'hA6);
        bus_mode = 1'b0;
        tally_and_finish();
    end
endmodule
`default_nettype wire
